// >>> hdl/clock_ratio_counter.sv
// Free-running period counter that flags the last system cycle of each bus clock period
`include "clkdiv_params.svh"
module clock_ratio_counter #(
  parameter int WIDTH = `CLKDIV_CNT_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [WIDTH-1:0] limit,
  output logic wrap
);
  logic [WIDTH-1:0] count;

  // Last cycle of the period; a limit of zero wraps every cycle
  assign wrap = (count == limit);

  // Count up to the limit and restart; the limit is compared unlatched, so a new limit bites in the current period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (ce) begin
      if (wrap) begin
        count <= '0;
      end else begin
        count <= count + 1'b1;
      end
    end
  end
endmodule

// >>> hdl/peripheral_bus_clock_divider.sv
// Peripheral bus clock divider with unlock-protected divisor control register
//
// Local design decisions: the address map and strobed register access.
`include "clkdiv_params.svh"
module peripheral_bus_clock_divider #(
  parameter int CNT_W = `CLKDIV_CNT_W
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic [`CLKDIV_ADDR_W-1:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  output logic PERIPHERAL_BUS_CLOCK_TICK,
  output logic DIVISOR_READY_FLAG
);
  clkdiv_pkg::divide_select_type bus_clock_divide_select;
  clkdiv_pkg::divide_select_type active_select;
  clkdiv_pkg::unlock_state_type unlock_state;
  logic divisor_ready_flag;
  logic wr_ctrl;
  logic wr_unlock;
  logic rd_ctrl;
  logic rd_unlock;
  logic accept_sel;
  logic [CNT_W-1:0] limit;
  logic wrap;
  logic [31:0] next_rdata;

  // Address decode
  always_comb begin
    wr_ctrl = 1'b0;
    wr_unlock = 1'b0;
    rd_ctrl = 1'b0;
    rd_unlock = 1'b0;
    if (ADDR == `CLKDIV_CTRL_OFFSET) begin
      wr_ctrl = WR;
      rd_ctrl = RD;
    end else if (ADDR == `CLKDIV_UNLOCK_OFFSET) begin
      wr_unlock = WR;
      rd_unlock = RD;
    end
  end

  // A select write lands only when unlocked and idle
  assign accept_sel = wr_ctrl && (unlock_state == clkdiv_pkg::UNLOCKED) && divisor_ready_flag;

  // Two-key unlock; any control write relocks so each change needs a fresh unlock
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      unlock_state <= clkdiv_pkg::LOCKED;
    end else if (CE) begin
      if (wr_ctrl) begin
        unlock_state <= clkdiv_pkg::LOCKED;
      end else if (wr_unlock) begin
        case (unlock_state)
          clkdiv_pkg::LOCKED: begin
            if (WDATA == `CLKDIV_KEY_FIRST) begin
              unlock_state <= clkdiv_pkg::KEY_ONE_SEEN;
            end
          end
          clkdiv_pkg::KEY_ONE_SEEN: begin
            if (WDATA == `CLKDIV_KEY_SECOND) begin
              unlock_state <= clkdiv_pkg::UNLOCKED;
            end else if (WDATA == `CLKDIV_KEY_FIRST) begin
              unlock_state <= clkdiv_pkg::KEY_ONE_SEEN;
            end else begin
              unlock_state <= clkdiv_pkg::LOCKED;
            end
          end
          default: begin
            unlock_state <= unlock_state;
          end
        endcase
      end
    end
  end

  // Requested divide selection as software sees it
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      bus_clock_divide_select <= clkdiv_pkg::divide_select_type'(`CLKDIV_SEL_RESET);
    end else if (CE && accept_sel) begin
      bus_clock_divide_select <=
        clkdiv_pkg::divide_select_type'(WDATA[`CLKDIV_SEL_MSB:`CLKDIV_SEL_LSB]);
    end
  end

  // Ready drops on a real change and returns when the new ratio is in use
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      divisor_ready_flag <= 1'b1;
    end else if (CE) begin
      if (accept_sel && (WDATA[`CLKDIV_SEL_MSB:`CLKDIV_SEL_LSB] != active_select)) begin
        divisor_ready_flag <= 1'b0;
      end else if (!divisor_ready_flag && wrap) begin
        divisor_ready_flag <= 1'b1;
      end
    end
  end

  // Ratio in use switches only on a period boundary, so no period is cut short
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      active_select <= clkdiv_pkg::divide_select_type'(`CLKDIV_SEL_RESET);
    end else if (CE && !divisor_ready_flag && wrap) begin
      active_select <= bus_clock_divide_select;
    end
  end

  // Period length from the selection: 1, 2, 4 or 8 system cycles
  always_comb begin
    case (active_select)
      clkdiv_pkg::DIV_BY_8: limit = CNT_W'(7);
      clkdiv_pkg::DIV_BY_4: limit = CNT_W'(3);
      clkdiv_pkg::DIV_BY_2: limit = CNT_W'(1);
      default: limit = CNT_W'(0);
    endcase
  end

  clock_ratio_counter #(
    .WIDTH(CNT_W)
  ) u_period (
    .clk(CLK),
    .rst_n(RST_N),
    .ce(CE),
    .limit(limit),
    .wrap(wrap)
  );

  // Tick is a registered enable; peripherals gate on it rather than on a derived clock edge
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      PERIPHERAL_BUS_CLOCK_TICK <= 1'b0;
    end else if (CE) begin
      PERIPHERAL_BUS_CLOCK_TICK <= wrap;
    end
  end

  // Ready mirrored to a pin for hardware that polls it
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      DIVISOR_READY_FLAG <= 1'b1;
    end else if (CE) begin
      DIVISOR_READY_FLAG <= divisor_ready_flag;
    end
  end

  // Read data; unused bits stay zero
  always_comb begin
    next_rdata = 32'h00000000;
    if (rd_ctrl) begin
      next_rdata[`CLKDIV_SEL_MSB:`CLKDIV_SEL_LSB] = bus_clock_divide_select;
      next_rdata[`CLKDIV_READY_BIT] = divisor_ready_flag;
    end else if (rd_unlock) begin
      next_rdata[`CLKDIV_UNLOCKED_BIT] = (unlock_state == clkdiv_pkg::UNLOCKED);
    end
  end

  // Read data stand one cycle after an enabled strobe and are zero after other enabled cycles; RDATA holds while CE is low
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= 32'h00000000;
    end else if (CE) begin
      RDATA <= next_rdata;
    end
  end

  // Checks on the block's own behaviour
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  property p_ready_accepts;
    CE && wr_ctrl && (unlock_state == clkdiv_pkg::UNLOCKED) && divisor_ready_flag
      |=> bus_clock_divide_select == $past(WDATA[`CLKDIV_SEL_MSB:`CLKDIV_SEL_LSB]);
  endproperty
  a_ready_accepts: assert property (p_ready_accepts) else $error("accepted select not stored");

  property p_busy_refuses;
    CE && wr_ctrl && !divisor_ready_flag |=> $stable(bus_clock_divide_select);
  endproperty
  a_busy_refuses: assert property (p_busy_refuses) else $error("select changed while switching");

  // The ready pin is a registered copy, so it follows the internal flag one cycle later
  property p_change_drops_ready;
    CE && accept_sel && (WDATA[`CLKDIV_SEL_MSB:`CLKDIV_SEL_LSB] != active_select) ##1 CE
      |-> !divisor_ready_flag ##1 !DIVISOR_READY_FLAG;
  endproperty
  a_change_drops_ready: assert property (p_change_drops_ready) else $error("ready did not drop");

  property p_locked_refuses;
    CE && wr_ctrl && (unlock_state != clkdiv_pkg::UNLOCKED) |=> $stable(bus_clock_divide_select);
  endproperty
  a_locked_refuses: assert property (p_locked_refuses) else $error("locked write took effect");

  property p_reserved_zero;
    CE && RD |=> (RDATA[31:12] == 20'h00000) && (RDATA[10:2] == 9'h000);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

  property p_div8_period;
    CE && wrap && divisor_ready_flag && (active_select == clkdiv_pkg::DIV_BY_8) ##1 CE[*7]
      |-> !wrap ##1 wrap;
  endproperty
  a_div8_period: assert property (p_div8_period) else $error("divide by 8 period wrong");

  property p_div2_period;
    CE && wrap && divisor_ready_flag && (active_select == clkdiv_pkg::DIV_BY_2) ##1 CE
      |-> !wrap ##1 wrap;
  endproperty
  a_div2_period: assert property (p_div2_period) else $error("divide by 2 period wrong");

  property p_switch_on_boundary;
    CE && !divisor_ready_flag && wrap |=> divisor_ready_flag && (active_select == bus_clock_divide_select);
  endproperty
  a_switch_on_boundary: assert property (p_switch_on_boundary) else $error("switch not completed");

  property p_switch_within;
    CE && accept_sel && (WDATA[`CLKDIV_SEL_MSB:`CLKDIV_SEL_LSB] != active_select) ##1 CE[*8]
      |-> ##[0:1] divisor_ready_flag;
  endproperty
  a_switch_within: assert property (p_switch_within) else $error("switch took too long");

  c_unlock_write: cover property (CE && accept_sel);
  c_refused_locked: cover property (CE && wr_ctrl && unlock_state == clkdiv_pkg::LOCKED);
  c_refused_busy: cover property (CE && wr_ctrl && !divisor_ready_flag);
  c_switch_done: cover property (CE && !divisor_ready_flag && wrap && bus_clock_divide_select == clkdiv_pkg::DIV_BY_8);
endmodule

// >>> inc/clkdiv_params.svh
// Constants for the peripheral bus clock divider
//
// Function
// - The divisor-ready flag reads 1 whenever no ratio change is under way, and a new divide selection is then accepted.
// - While a ratio change is under way the divisor-ready flag reads 0 and writes to the divide selection are refused.
// - The bus clock tick is the system clock divided by 8, 4, 2 or 1 for selection 11, 10, 01 or 00.
// - Software unlocks before writing the divisor control register, and the block takes such writes only after it.
// - Bits 31 to 12 and 10 to 2 of the divisor control register always read as zero.
`ifndef CLKDIV_PARAMS_SVH
`define CLKDIV_PARAMS_SVH

`define CLKDIV_ADDR_W 8
`define CLKDIV_CTRL_OFFSET 8'h00
`define CLKDIV_UNLOCK_OFFSET 8'h04
`define CLKDIV_SEL_LSB 0
`define CLKDIV_SEL_MSB 1
`define CLKDIV_READY_BIT 11
`define CLKDIV_UNLOCKED_BIT 0
`define CLKDIV_SEL_RESET 2'h0
`define CLKDIV_KEY_FIRST 32'h5a5a0001
`define CLKDIV_KEY_SECOND 32'ha5a50002
`define CLKDIV_CNT_W 3

`endif

// >>> inc/clkdiv_pkg.sv
// Types shared by the peripheral bus clock divider
package clkdiv_pkg;
  typedef enum logic [1:0] {
    DIV_BY_1,
    DIV_BY_2,
    DIV_BY_4,
    DIV_BY_8
  } divide_select_type;

  typedef enum logic [1:0] {
    LOCKED,
    KEY_ONE_SEEN,
    UNLOCKED
  } unlock_state_type;
endpackage

// >>> testbench/bus_tick_consumer.sv
// Peripheral model running on the divided bus clock; measures its period
module bus_tick_consumer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  output logic [7:0] period
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] count;
  // Cycles between bus clock edges; a runt at a switch shows as a short period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 8'h01;
      period <= 8'h00;
    end else if (tick) begin
      period <= count;
      count <= 8'h01;
    end else begin
      count <= count + 8'h01;
    end
  end
endmodule

// >>> testbench/peripheral_bus_clock_divider_bench.sv
// Self-checking bench for the peripheral bus clock divider
`include "clkdiv_params.svh"
module peripheral_bus_clock_divider_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] CTRL = `CLKDIV_CTRL_OFFSET;
  localparam logic [7:0] UNLK = `CLKDIV_UNLOCK_OFFSET;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic CE = 1'b1;
  logic [7:0] ADDR = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [31:0] RDATA;
  logic TICK;
  logic READY;
  logic [7:0] period;
  logic tick_s = 1'b0;
  logic rdy_s = 1'b0;
  logic rd_taken = 1'b0;
  logic [31:0] exp_q[$];
  logic [15:0] lfsr = 16'h0023;
  int n_mismatch = 0;
  int checks_done = 0;
  int i;

  always #50 CLK = ~CLK;

  peripheral_bus_clock_divider #(.CNT_W(3)) u_dut (.CLK(CLK), .RST_N(RST_N), .CE(CE), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .PERIPHERAL_BUS_CLOCK_TICK(TICK),
    .DIVISOR_READY_FLAG(READY));
  bus_tick_consumer u_periph (.clk(CLK), .rst_n(RST_N), .tick(TICK), .period(period));

  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic compare(input string name, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic compare_read(input logic [31:0] e, input logic [31:0] g);
    compare("read data", e, g);
  endtask

  task automatic compare_ready(input logic g);
    compare("ready flag", 32'h1, {31'h0, g});
  endtask

  task automatic compare_period(input logic [31:0] e, input logic [7:0] g);
    compare("tick period", e, {24'h0, g});
  endtask

  // Strobes are set on every call, so back-to-back calls never assign twice in one step
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
    WR <= w;
    RD <= r;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK);
  endtask

  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, CTRL, 32'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, a, 32'h0);
  endtask

  task automatic unlock();
    bus(1'b1, 1'b0, UNLK, `CLKDIV_KEY_FIRST);
    bus(1'b1, 1'b0, UNLK, `CLKDIV_KEY_SECOND);
  endtask

  // Wait out a ratio change, then measure the period the peripheral sees
  task automatic settle(input logic [1:0] s);
    int j;
    idle(3);
    for (j = 0; j < 12 && rdy_s !== 1'b1; j++) idle(1);
    compare_ready(rdy_s);
    rd(CTRL, 32'h800 | {30'h0, s});
    idle(20);
    compare_period(32'h1 << s, period);
  endtask

  task automatic conclude();
    $display("Checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Read data stand in the cycle after the read strobe is taken
  always @(posedge CLK) rd_taken <= RD;
  always @(negedge CLK) begin
    tick_s <= TICK;
    rdy_s <= READY;
    if (rd_taken) compare_read(exp_q.pop_front(), RDATA);
  end

  initial begin
    #200000;
    n_mismatch++;
    conclude();
  end

  initial begin
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    rd(CTRL, 32'h800);
    rd(UNLK, 32'h0);
    rd(8'h08, 32'h0);
    bus(1'b1, 1'b0, CTRL, 32'h3);
    rd(CTRL, 32'h800);
    // Random upper bits must not show in the read-back
    for (i = 1; i < 4; i++) begin
      unlock();
      rd(UNLK, 32'h1);
      lfsr = lfsr_next(lfsr);
      bus(1'b1, 1'b0, CTRL, {lfsr, lfsr[15:2], i[1:0]});
      settle(i[1:0]);
    end
    // Start a change just after a wrap, then retry while it is still pending
    unlock();
    for (i = 0; i < 10 && tick_s !== 1'b1; i++) idle(1);
    compare("tick seen", 32'h1, {31'h0, tick_s});
    bus(1'b1, 1'b0, CTRL, 32'h0);
    unlock();
    bus(1'b1, 1'b0, CTRL, 32'h1);
    rd(CTRL, 32'h0);
    settle(2'h0);
    // Keys offered while the clock enable is low must not unlock anything
    CE <= 1'b0;
    unlock();
    CE <= 1'b1;
    rd(UNLK, 32'h0);
    idle(2);
    conclude();
  end
endmodule
